// >>> core/fmst_params.svh
/*
  Register offsets, field positions, reset values and sizes of the
  FIFO and modem status block. Assumes inclusion by bare name.
*/
`ifndef FMST_PARAMS_SVH
`define FMST_PARAMS_SVH
`define FMST_ADR_STATUS2   6'h08
`define FMST_ADR_DATA      6'h09
`define FMST_ADR_LEVEL     6'h0A
`define FMST_ADR_THRESH    6'h0B
`define FMST_BIT_FORCE     6
`define FMST_BIT_CIPHER    3
`define FMST_BIT_FLUSH     7
`define FMST_THRESH_RST    6'h08
`define FMST_DEPTH         64
`define FMST_WAITW         16
`define FMST_LS_IDLE       3'h0
`define FMST_LS_LAUNCH     3'h1
`define FMST_LS_PRE_TRANSMIT_WAIT     3'h2
`define FMST_LS_TX         3'h3
`define FMST_LS_PRE_RECEIVE_WAIT     3'h4
`define FMST_LS_DWAIT      3'h5
`define FMST_LS_RX         3'h6
`endif

// >>> core/fmst_pkg.sv
/*
  Types of the FIFO and modem status block.
  Assumes fmst_params.svh is on the include path.
*/
package fmst_pkg;
    // One-hot link states.
    typedef enum logic [6:0] {
        FMST_IDLE   = 7'h01,
        FMST_LAUNCH = 7'h02,
        FMST_PRE_TRANSMIT_WAIT = 7'h04,
        FMST_TX     = 7'h08,
        FMST_PRE_RECEIVE_WAIT = 7'h10,
        FMST_DWAIT  = 7'h20,
        FMST_RX     = 7'h40
    } fmst_state_t;
    // Register port request.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } fmst_req_t;
    // Modem side events.
    typedef struct packed {
        logic start;
        logic launch;
        logic tx_done;
        logic rx_start;
        logic rx_done;
        logic stop;
        logic auth_ok;
        logic field_on;
    } fmst_mdm_t;
endpackage

// >>> core/fmst_core.sv
/*
  FIFO and modem status block: 64-byte buffer with level, flush and watermark alerts, plus link-state,
  cipher and filter status bits. Assumes a synchronous host register port and a modem byte port, all on clk.
*/
`timescale 1ns/10ps
`include "fmst_params.svh"
module fmst_core
    import fmst_pkg::*;
#(
    parameter int DEPTH = `FMST_DEPTH,
    parameter int WAITW = `FMST_WAITW
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire fmst_req_t         req,
    output logic [7:0]             rdata,
    input  wire fmst_mdm_t         mdm,
    input  wire logic              wait_for_field,
    input  wire logic [WAITW-1:0]  transmit_wait_setting,
    input  wire logic [WAITW-1:0]  receive_wait_setting,
    input  wire logic              proto_fast,
    input  wire logic              modem_push,
    input  wire logic [7:0]        modem_wbyte,
    input  wire logic              modem_pop,
    output logic [7:0]             modem_rbyte,
    output logic                   fifo_full,
    output logic                   fifo_empty,
    output logic                   near_full_alert,
    output logic                   near_empty_alert,
    output logic                   buffer_overflow_error,
    output logic [2:0]             link_state,
    output logic                   cipher_active,
    output logic                   force_fast_filter,
    output logic                   fast_filter
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    // Elaboration check on the buffer size and the wait counter width.
    if (DEPTH < 2 || DEPTH > 64 || (DEPTH & (DEPTH - 1)) != 0 || WAITW < 1) begin : g_chk
        $error("DEPTH must be a power of two from 2 to 64 and WAITW at least 1");
    end

    //--------------------------------------------------------------
    // Buffer storage and counters
    //--------------------------------------------------------------
    logic [7:0]        mem [DEPTH];
    logic [AW-1:0]     wptr;
    logic [AW-1:0]     rptr;
    logic [CW-1:0]     count;
    logic [5:0]        alert_threshold;
    fmst_state_t       state;
    logic [WAITW-1:0]  wait_cnt;
    // Host access to the data port takes priority over the modem.
    logic host_wr;
    logic host_rd;
    logic flush;
    logic push;
    logic pop;
    logic push_ok;
    logic pop_ok;
    logic [CW-1:0] next_count;
    assign host_wr   = req.wr && req.addr == `FMST_ADR_DATA;
    assign host_rd   = req.rd && req.addr == `FMST_ADR_DATA;
    assign flush     = req.wr && req.addr == `FMST_ADR_LEVEL && req.wdata[`FMST_BIT_FLUSH];
    assign push      = host_wr | (modem_push & ~(host_wr | host_rd));
    assign pop       = host_rd | (modem_pop & ~(host_wr | host_rd));
    assign push_ok   = push && count != CW'(DEPTH);
    assign pop_ok    = pop && count != '0;

    // Count moves by one per accepted write and read.
    always_comb begin
        next_count = count;
        if (push_ok && !pop_ok) begin
            next_count = count + CW'(1);
        end else if (pop_ok && !push_ok) begin
            next_count = count - CW'(1);
        end
    end

    // Pointers and count, cleared by a flush.
    always_ff @(posedge clk) begin
        if (rst) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else if (flush) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            if (push_ok) begin
                wptr <= wptr + AW'(1);
            end
            if (pop_ok) begin
                rptr <= rptr + AW'(1);
            end
            count <= next_count;
        end
    end

    // Byte storage has no reset.
    always_ff @(posedge clk) begin
        if (push_ok && !flush) begin
            mem[wptr] <= host_wr ? req.wdata : modem_wbyte;
        end
    end

    // Modem read byte, held until the next modem pop.
    always_ff @(posedge clk) begin
        if (rst) begin
            modem_rbyte <= 8'h00;
        end else if (pop_ok && !host_rd && !flush) begin
            modem_rbyte <= mem[rptr];
        end
    end

    // Overflow error: a dropped write wins over a flush in one cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            buffer_overflow_error <= 1'b0;
        end else if (push && !push_ok) begin
            buffer_overflow_error <= 1'b1;
        end else if (flush) begin
            buffer_overflow_error <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // Threshold, alerts and flags
    //--------------------------------------------------------------
    // Watermark register.
    always_ff @(posedge clk) begin
        if (rst) begin
            alert_threshold <= `FMST_THRESH_RST;
        end else if (req.wr && req.addr == `FMST_ADR_THRESH) begin
            alert_threshold <= req.wdata[5:0];
        end
    end

    // Alerts and full/empty follow the live count one cycle later.
    always_ff @(posedge clk) begin
        if (rst) begin
            near_full_alert  <= 1'b0;
            near_empty_alert <= 1'b1;
            fifo_full        <= 1'b0;
            fifo_empty       <= 1'b1;
        end else begin
            near_full_alert  <= (CW'(DEPTH) - count) <= CW'(alert_threshold);
            near_empty_alert <= count <= CW'(alert_threshold);
            fifo_full        <= count == CW'(DEPTH);
            fifo_empty       <= count == '0;
        end
    end

    // Cipher flag: authentication set wins over a software clear.
    always_ff @(posedge clk) begin
        if (rst) begin
            cipher_active <= 1'b0;
        end else if (mdm.auth_ok) begin
            cipher_active <= 1'b1;
        end else if (req.wr && req.addr == `FMST_ADR_STATUS2 && !req.wdata[`FMST_BIT_CIPHER]) begin
            cipher_active <= 1'b0;
        end
    end

    // Filter force bit and resulting filter mode.
    always_ff @(posedge clk) begin
        if (rst) begin
            force_fast_filter <= 1'b0;
            fast_filter       <= 1'b0;
        end else begin
            if (req.wr && req.addr == `FMST_ADR_STATUS2) begin
                force_fast_filter <= req.wdata[`FMST_BIT_FORCE];
            end
            fast_filter <= force_fast_filter | proto_fast;
        end
    end

    //--------------------------------------------------------------
    // Link state machine
    //--------------------------------------------------------------
    logic wait_done;
    assign wait_done = wait_cnt == '0 && (!wait_for_field || mdm.field_on);

    // Sequencing of transmit and receive phases.
    always_ff @(posedge clk) begin
        if (rst) begin
            state    <= FMST_IDLE;
            wait_cnt <= '0;
        end else if (mdm.stop) begin
            state    <= FMST_IDLE;
            wait_cnt <= '0;
        end else begin
            if (wait_cnt != '0) begin
                wait_cnt <= wait_cnt - WAITW'(1);
            end
            case (state)
                FMST_IDLE: begin
                    if (mdm.start) begin
                        state <= FMST_LAUNCH;
                    end
                end
                FMST_LAUNCH: begin
                    if (mdm.launch) begin
                        state    <= FMST_PRE_TRANSMIT_WAIT;
                        wait_cnt <= transmit_wait_setting;
                    end
                end
                FMST_PRE_TRANSMIT_WAIT: begin
                    if (wait_done) begin
                        state <= FMST_TX;
                    end
                end
                FMST_TX: begin
                    if (mdm.tx_done) begin
                        state    <= FMST_PRE_RECEIVE_WAIT;
                        wait_cnt <= receive_wait_setting;
                    end
                end
                FMST_PRE_RECEIVE_WAIT: begin
                    if (wait_done) begin
                        state <= FMST_DWAIT;
                    end
                end
                FMST_DWAIT: begin
                    if (mdm.rx_start) begin
                        state <= FMST_RX;
                    end
                end
                FMST_RX: begin
                    if (mdm.rx_done) begin
                        state <= FMST_IDLE;
                    end
                end
                default: begin
                    state <= FMST_IDLE;
                end
            endcase
        end
    end

    // Encoded link state, registered one cycle behind the machine.
    always_ff @(posedge clk) begin
        if (rst) begin
            link_state <= `FMST_LS_IDLE;
        end else begin
            case (state)
                FMST_LAUNCH: link_state <= `FMST_LS_LAUNCH;
                FMST_PRE_TRANSMIT_WAIT: link_state <= `FMST_LS_PRE_TRANSMIT_WAIT;
                FMST_TX:     link_state <= `FMST_LS_TX;
                FMST_PRE_RECEIVE_WAIT: link_state <= `FMST_LS_PRE_RECEIVE_WAIT;
                FMST_DWAIT:  link_state <= `FMST_LS_DWAIT;
                FMST_RX:     link_state <= `FMST_LS_RX;
                default:     link_state <= `FMST_LS_IDLE;
            endcase
        end
    end

    //--------------------------------------------------------------
    // Register read path
    //--------------------------------------------------------------
    // Read data is registered one cycle after the strobe.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            if (req.addr == `FMST_ADR_STATUS2) begin
                rdata <= {1'b0, force_fast_filter, 2'b00, cipher_active, link_state};
            end else if (req.addr == `FMST_ADR_DATA) begin
                rdata <= pop_ok ? mem[rptr] : 8'h00;
            end else if (req.addr == `FMST_ADR_LEVEL) begin
                rdata <= {1'b0, 7'(count)};
            end else if (req.addr == `FMST_ADR_THRESH) begin
                rdata <= {2'b00, alert_threshold};
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    AST_FLUSH: assert property (@(posedge clk) disable iff (rst)
        flush |=> count == '0 && wptr == '0 && rptr == '0)
        else $error("flush did not empty the buffer");
    AST_INC: assert property (@(posedge clk) disable iff (rst)
        host_wr && !flush && count < CW'(DEPTH) && !req.rd |=> count == $past(count) + CW'(1))
        else $error("write did not add one");
    AST_DEC: assert property (@(posedge clk) disable iff (rst)
        host_rd && !flush && count != '0 && !modem_push |=> count == $past(count) - CW'(1))
        else $error("read did not subtract one");
    AST_OVF: assert property (@(posedge clk) disable iff (rst)
        host_wr && count == CW'(DEPTH) |=> buffer_overflow_error && count == CW'(DEPTH))
        else $error("full write not refused");
    AST_LVL_RD: assert property (@(posedge clk) disable iff (rst)
        req.rd && req.addr == `FMST_ADR_LEVEL |=> !rdata[7] && rdata[6:0] == 7'($past(count)))
        else $error("level read wrong");
    AST_HI: assert property (@(posedge clk) disable iff (rst)
        ##1 near_full_alert == ((CW'(DEPTH) - $past(count)) <= CW'($past(alert_threshold))))
        else $error("near-full alert wrong");
    AST_LO: assert property (@(posedge clk) disable iff (rst)
        ##1 near_empty_alert == ($past(count) <= CW'($past(alert_threshold))))
        else $error("near-empty alert wrong");
    AST_CIPHER: assert property (@(posedge clk) disable iff (rst)
        !cipher_active && !mdm.auth_ok |=> !cipher_active)
        else $error("cipher flag set without authentication");
    AST_FILTER: assert property (@(posedge clk) disable iff (rst)
        force_fast_filter |=> fast_filter)
        else $error("forced filter not fast");
    AST_PRE_TRANSMIT_WAIT: assert property (@(posedge clk) disable iff (rst)
        state == FMST_PRE_TRANSMIT_WAIT && wait_for_field && !mdm.field_on && !mdm.stop |=> state == FMST_PRE_TRANSMIT_WAIT)
        else $error("left transmit wait without field");
    AST_PRE_RECEIVE_WAIT: assert property (@(posedge clk) disable iff (rst)
        state == FMST_PRE_RECEIVE_WAIT && wait_cnt != '0 && !mdm.stop |=> state == FMST_PRE_RECEIVE_WAIT)
        else $error("left receive wait early");
    AST_CODE: assert property (@(posedge clk) disable iff (rst)
        state == FMST_TX |=> link_state == `FMST_LS_TX)
        else $error("transmit code wrong");
endmodule // fmst_core

// >>> bench/fmst_host_model.sv
/*
  Host processor model: issues single register reads and writes on the
  block's register port. Assumes the block samples requests on rising clk.
*/
`timescale 1ns/10ps
module fmst_host_model
    import fmst_pkg::*;
(
    input  wire logic       clk,
    output fmst_req_t       req,
    input  wire logic [7:0] rdata
);
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    initial begin
        req = '0;
    end

    // One write, then one idle cycle so strobes never touch twice.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        #1;
        req = '0;
        @(posedge clk);
        #1;
    endtask

    // One read; the answer is taken right after the accepting edge.
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        #1;
        d = rdata;
        req = '0;
        @(posedge clk);
        #1;
    endtask

    // Empties the buffer before fresh data is loaded.
    task automatic flush();
        wr(6'h0A, 8'h80);
    endtask
endmodule // fmst_host_model

// >>> bench/fmst_core_bench.sv
/*
  Self-checking bench of the FIFO and modem status block.
  Assumes the host model file and the design files are compiled first.
*/
`timescale 1ns/10ps
module fmst_core_bench;
    import fmst_pkg::*;
    logic        clk;
    logic        rst;
    fmst_req_t   req;
    logic [7:0]  rdata;
    fmst_mdm_t   mdm;
    logic        wait_for_field;
    logic [15:0] tx_wait;
    logic [15:0] rx_wait;
    logic        proto_fast;
    logic        modem_push;
    logic [7:0]  modem_wbyte;
    logic        modem_pop;
    logic [7:0]  modem_rbyte;
    logic        fifo_full;
    logic        fifo_empty;
    logic        near_full_alert;
    logic        near_empty_alert;
    logic        buffer_overflow_error;
    logic [2:0]  link_state;
    logic        cipher_active;
    logic        force_fast_filter;
    logic        fast_filter;
    logic [7:0]  d;
    int          n_mismatch;
    int          cmp_count;

    fmst_core dut_u (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .mdm(mdm),
        .wait_for_field(wait_for_field), .transmit_wait_setting(tx_wait),
        .receive_wait_setting(rx_wait), .proto_fast(proto_fast), .modem_push(modem_push),
        .modem_wbyte(modem_wbyte), .modem_pop(modem_pop), .modem_rbyte(modem_rbyte),
        .fifo_full(fifo_full), .fifo_empty(fifo_empty), .near_full_alert(near_full_alert),
        .near_empty_alert(near_empty_alert), .buffer_overflow_error(buffer_overflow_error),
        .link_state(link_state), .cipher_active(cipher_active),
        .force_fast_filter(force_fast_filter), .fast_filter(fast_filter));
    fmst_host_model host_u (.clk(clk), .req(req), .rdata(rdata));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Clock of 100 ns period.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // One-cycle modem event; field_on is kept as it was.
    task automatic ev(input logic [7:0] m);
        mdm = mdm | fmst_mdm_t'(m);
        tick(1);
        mdm = mdm & ~fmst_mdm_t'(m);
    endtask

    // Waits a bounded number of cycles for a link code, then compares.
    task automatic wait_ls(input logic [2:0] c, input int lim);
        for (int i = 0; i < lim && link_state !== c; i++) tick(1);
        check({5'h0, link_state}, {5'h0, c}, "link state");
    endtask

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        host_u.rd(6'h0A, d); check(d, 8'h00, "level");
        host_u.rd(6'h0B, d); check(d, 8'h08, "threshold");
        host_u.rd(6'h08, d); check(d, 8'h00, "status2");
        host_u.rd(6'h3F, d); check(d, 8'h00, "unmapped");
        check({7'h0, near_empty_alert}, 8'h01, "near empty");
        check({6'h0, fifo_full, fifo_empty}, 8'h01, "full and empty after reset");
        check({6'h0, near_full_alert, buffer_overflow_error}, 8'h00, "alert and overflow after reset");
        $display("test reset done");
    endtask

    task automatic t_order();
        host_u.flush();
        for (int i = 0; i < 3; i++) host_u.wr(6'h09, 8'hA0 + 8'(i));
        host_u.rd(6'h0A, d); check(d, 8'h03, "level after writes");
        for (int i = 0; i < 3; i++) begin
            host_u.rd(6'h09, d); check(d, 8'hA0 + 8'(i), "fifo order");
        end
        host_u.rd(6'h09, d);
        check(d, 8'h00, "empty data read");
        host_u.rd(6'h0A, d); check(d, 8'h00, "empty read");
        modem_wbyte = 8'h5C; modem_push = 1'b1; tick(1); modem_push = 1'b0;
        host_u.rd(6'h09, d); check(d, 8'h5C, "modem to host");
        host_u.wr(6'h09, 8'h3E);
        modem_pop = 1'b1; tick(1); modem_pop = 1'b0;
        check(modem_rbyte, 8'h3E, "host to modem");
        $display("test order done");
    endtask

    task automatic t_fill();
        host_u.wr(6'h0B, 8'hFF);
        host_u.rd(6'h0B, d); check(d, 8'h3F, "threshold bits");
        host_u.wr(6'h0B, 8'h04);
        host_u.flush();
        for (int i = 1; i <= 64; i++) begin
            host_u.wr(6'h09, 8'(i));
            check({7'h0, near_empty_alert}, {7'h0, i <= 4}, "near empty");
            check({7'h0, near_full_alert}, {7'h0, 64 - i <= 4}, "near full");
        end
        check({7'h0, fifo_full}, 8'h01, "full flag");
        host_u.wr(6'h09, 8'hEE);
        check({7'h0, buffer_overflow_error}, 8'h01, "overflow");
        host_u.rd(6'h0A, d); check(d, 8'h40, "full level");
        host_u.wr(6'h0A, 8'h80);
        host_u.rd(6'h0A, d); check(d, 8'h00, "flushed level");
        check({7'h0, buffer_overflow_error}, 8'h00, "overflow cleared");
        check({7'h0, fifo_empty}, 8'h01, "empty flag after flush");
        $display("test fill done");
    endtask

    task automatic t_link();
        wait_for_field = 1'b1; tx_wait = 16'h0003; rx_wait = 16'h0006;
        ev(8'h80); wait_ls(3'h1, 4);
        ev(8'h40); wait_ls(3'h2, 4);
        tick(10); check({5'h0, link_state}, 8'h02, "held for field");
        mdm.field_on = 1'b1; wait_ls(3'h3, 8);
        ev(8'h20); wait_ls(3'h4, 4);
        for (int i = 0; i < 6; i++) begin
            check({5'h0, link_state}, 8'h04, "receive wait");
            tick(1);
        end
        wait_ls(3'h5, 8);
        ev(8'h10); wait_ls(3'h6, 4);
        ev(8'h08); wait_ls(3'h0, 4);
        ev(8'h80); wait_ls(3'h1, 4);
        ev(8'h04); wait_ls(3'h0, 4);
        ev(8'h80); wait_ls(3'h1, 4);
        ev(8'h40); wait_ls(3'h2, 4);
        // With the field present the transmit wait still lasts its minimum time.
        for (int i = 0; i < 3; i++) begin
            tick(1);
            check({5'h0, link_state}, 8'h02, "transmit wait time");
        end
        wait_ls(3'h3, 4);
        ev(8'h04); wait_ls(3'h0, 4);
        $display("test link done");
    endtask

    task automatic t_status();
        ev(8'h02); tick(1);
        host_u.rd(6'h08, d); check(d, 8'h08, "cipher set");
        check({7'h0, cipher_active}, 8'h01, "cipher flag");
        host_u.wr(6'h08, 8'h40); tick(1);
        host_u.rd(6'h08, d); check(d, 8'h40, "cipher clear force on");
        check({6'h0, force_fast_filter, cipher_active}, 8'h02, "force bit and cipher flag");
        check({7'h0, fast_filter}, 8'h01, "forced fast");
        host_u.wr(6'h08, 8'h00); tick(1);
        check({7'h0, fast_filter}, 8'h00, "slow protocol");
        proto_fast = 1'b1; tick(2);
        check({7'h0, fast_filter}, 8'h01, "fast protocol");
        $display("test status done");
    endtask

    // Reset in mid-run returns the level and the threshold to their reset values.
    task automatic t_rerst();
        host_u.wr(6'h09, 8'h11);
        host_u.wr(6'h09, 8'h22);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        host_u.rd(6'h0A, d);
        check(d, 8'h00, "level after mid reset");
        host_u.rd(6'h0B, d);
        check(d, 8'h08, "threshold after mid reset");
        $display("test mid reset done");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        n_mismatch = 0; cmp_count = 0; rst = 1'b1; mdm = '0; wait_for_field = 1'b0;
        tx_wait = 16'h0000; rx_wait = 16'h0000; proto_fast = 1'b0; modem_push = 1'b0;
        modem_wbyte = 8'h00; modem_pop = 1'b0;
        tick(20);
        rst = 1'b0;
        t_reset(); t_order(); t_fill(); t_link(); t_status(); t_rerst();
        print_verdict();
    end

    // Cuts a hang short well past the expected run of under 1000 cycles.
    initial begin
        #(5000 * 100);
        n_mismatch++;
        print_verdict();
    end
endmodule // fmst_core_bench
